// file: hw/cod_decoder.sv
// Operand and branch decoder that fetches instruction bytes and resolves branches.
`timescale 1ns/1ps
module cod_decoder (
	input  wire logic                sys_clk,
	input  wire logic                srst,
	input  wire logic                pm_valid,
	input  wire logic [7:0]          pm_data,
	output logic                     pm_ready,
	input  wire cod_pkg::cod_flags_t cur_flags,
	output logic [3:0]               wreg_sel,
	input  wire logic [7:0]          wreg_val,
	input  wire logic [15:0]         pc_seq,
	input  wire logic [11:0]         sp_in,
	output logic                     stk_req,
	output logic [11:0]              stk_addr,
	input  wire logic                stk_ack,
	input  wire logic [7:0]          stk_data,
	output cod_pkg::cod_result_t     result,
	output logic                     busy
);
	import cod_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		cod_state_t  st;
		logic [7:0]  opcode;
		logic [2:0]  left;
		logic [1:0]  idx;
		logic [23:0] ob;
		cod_info_t   info;
		logic [11:0] sp_base;
		cod_result_t res;
	} cod_dec_state_t;

	cod_dec_state_t s_r;
	cod_dec_state_t s_nxt;
	cod_info_t      rom_info;
	logic           take;
	logic [7:0]     dec_val;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Evaluates a four-bit condition code against the flags.
	function automatic logic cond_true(input logic [3:0] cc, input cod_flags_t f);
		logic lt;
		lt = f.s ^ f.v;
		case (cc)
			4'h0: cond_true = 1'b0;
			4'h1: cond_true = lt;
			4'h2: cond_true = f.z | lt;
			4'h3: cond_true = f.c | f.z;
			4'h4: cond_true = f.v;
			4'h5: cond_true = f.s;
			4'h6: cond_true = f.z;
			4'h7: cond_true = f.c;
			4'h8: cond_true = 1'b1;
			4'h9: cond_true = ~lt;
			4'hA: cond_true = ~(f.z | lt);
			4'hB: cond_true = ~(f.c | f.z);
			4'hC: cond_true = ~f.v;
			4'hD: cond_true = ~f.s;
			4'hE: cond_true = ~f.z;
			default: cond_true = ~f.c;
		endcase
	endfunction

	// Splits the operand bytes into every operand class.
	function automatic cod_opnd_t extract(
		input logic [7:0]  op,
		input logic [23:0] ob,
		input logic [2:0]  nb
	);
		logic [7:0] b1;
		logic [7:0] b2;
		logic [7:0] last;
		b1 = ob[7:0];
		b2 = ob[15:8];
		case (nb)
			3'd3: last = b2;
			3'd4: last = ob[23:16];
			default: last = b1;
		endcase
		extract = '0;
		extract.bit_idx = b1[6:4];
		extract.polarity = b1[7];
		extract.direct_address_operand = {b1, b2};
		extract.extended_reg_operand = {b1, b2[7:4]};
		extract.immediate_operand = last;
		extract.reg_pair_addr = {b1[7:1], 1'b0};
		extract.work_pair = {b1[3:1], 1'b0};
		extract.work_reg = (op[3:0] >= 4'hA && op[3:0] <= 4'hE) ? op[7:4] : b1[7:4];
		extract.rel_disp = last;
		extract.condition_field = op[7:4];
	endfunction

	// ----------------------------------------------------------------
	// Opcode table
	// ----------------------------------------------------------------
	cod_op_rom u_rom (
		.sys_clk (sys_clk),
		.srst    (srst),
		.opcode  (pm_data),
		.info_r  (rom_info)
	);

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------

	// Byte handshake and stack request are decoded from the state.
	assign pm_ready = (s_r.st == ST_IDLE) || (s_r.st == ST_OPND);
	assign take = pm_ready && pm_valid;
	assign stk_req = (s_r.st == ST_POP_F) || (s_r.st == ST_POP_H) || (s_r.st == ST_POP_L);
	assign busy = (s_r.st != ST_IDLE);

	// Data outputs come straight from the state register.
	assign result = s_r.res;
	assign wreg_sel = s_r.opcode[7:4];
	assign dec_val = wreg_val - 8'd1;

	// Stack address walks flags, then PC high, then PC low.
	always_comb begin
		case (s_r.st)
			ST_POP_H: stk_addr = s_r.sp_base + SP_STEP_FLAGS;
			ST_POP_L: stk_addr = s_r.sp_base + SP_STEP_PC;
			default:  stk_addr = s_r.sp_base;
		endcase
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------

	// Collects bytes, decodes operands and resolves the branch outcome.
	always_comb begin
		s_nxt = s_r;
		s_nxt.res.valid = 1'b0;
		case (s_r.st)
			ST_IDLE: begin
				if (take) begin
					s_nxt.opcode = pm_data;
					s_nxt.ob = '0;
					s_nxt.idx = 2'd0;
					s_nxt.st = ST_LOOK;
				end
			end
			ST_LOOK: begin
				s_nxt.info = rom_info;
				s_nxt.left = rom_info.nbytes - 3'd1;
				s_nxt.st = (rom_info.nbytes == 3'd1) ? ST_EXEC : ST_OPND;
			end
			ST_OPND: begin
				if (take) begin
					s_nxt.ob[s_r.idx*8 +: 8] = pm_data;
					s_nxt.idx = s_r.idx + 2'd1;
					s_nxt.left = s_r.left - 3'd1;
					if (s_r.left == 3'd1)
						s_nxt.st = ST_EXEC;
				end
			end
			ST_EXEC: begin
				s_nxt.res = '0;
				s_nxt.res.opcode = s_r.opcode;
				s_nxt.res.info = s_r.info;
				s_nxt.res.opnd = extract(s_r.opcode, s_r.ob, s_r.info.nbytes);
				s_nxt.res.flags = cur_flags;
				s_nxt.res.sp_out = sp_in;
				s_nxt.res.pc_target = pc_seq;
				s_nxt.res.valid = 1'b1;
				s_nxt.st = ST_IDLE;
				if (s_r.opcode == OPC_RETURN_FROM_INTERRUPT) begin
					s_nxt.res.valid = 1'b0;
					s_nxt.sp_base = sp_in;
					s_nxt.st = ST_POP_F;
				end else if (s_r.opcode[3:0] == LO_DECREMENT_BRANCH) begin
					s_nxt.res.wb_en = 1'b1;
					s_nxt.res.wb_reg = s_r.opcode[7:4];
					s_nxt.res.wb_val = dec_val;
					if (dec_val != 8'h00) begin
						s_nxt.res.pc_load = 1'b1;
						s_nxt.res.pc_target = pc_seq +
							{{8{s_r.ob[7]}}, s_r.ob[7:0]};
					end
				end else if (s_r.opcode[3:0] == LO_ABSOLUTE_JUMP_CC) begin
					if (cond_true(s_r.opcode[7:4], cur_flags)) begin
						s_nxt.res.pc_load = 1'b1;
						s_nxt.res.pc_target = {s_r.ob[7:0], s_r.ob[15:8]};
					end
				end
			end
			ST_POP_F: begin
				if (stk_ack) begin
					s_nxt.res.flags = stk_data[FLAGS_BYTE_TOP -: 6];
					s_nxt.st = ST_POP_H;
				end
			end
			ST_POP_H: begin
				if (stk_ack) begin
					s_nxt.res.pc_target[15:8] = stk_data;
					s_nxt.st = ST_POP_L;
				end
			end
			ST_POP_L: begin
				if (stk_ack) begin
					s_nxt.res.pc_target[7:0] = stk_data;
					s_nxt.res.pc_load = 1'b1;
					s_nxt.res.sp_out = s_r.sp_base + SP_STEP_FLAGS + SP_STEP_PC;
					s_nxt.res.ie_set = 1'b1;
					s_nxt.res.valid = 1'b1;
					s_nxt.st = ST_IDLE;
				end
			end
			default: s_nxt.st = ST_IDLE;
		endcase
	end

	// Registers the whole state.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_r <= '{st: ST_IDLE, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

endmodule

// file: hw/cod_pkg.sv
// Shared types and constants of the CPU operand and branch decoder.
// Contract
// - Bit-select operand is three bits choosing one of eight positions, 000 to 111.
// - Direct address operand is a full sixteen-bit address, 0000 to FFFF.
// - Extended register operand is a twelve-bit register file address, 000 to FFF.
// - Immediate operand is one literal byte, any value 00 to FF.
// - Indirect register-pair operand is an even eight-bit address, 00 to FE.
// - Working register pair operand selects only even registers 0 to 14.
// - Polarity operand is one bit selecting the tested bit state.
// - Result flags come from result, unaffected flags keep value, undefined are free.
// - Return from interrupt pops flags, SP+1, pops PC, SP+2, sets interrupt enable.
// - Decrement-and-branch decrements register, adds displacement to PC only when nonzero.
// - Conditional absolute jump loads direct address only when condition is true.
package cod_pkg;

	// ----------------------------------------------------------------
	// Opcode encodings and field positions
	// ----------------------------------------------------------------
	localparam logic [7:0]  OPC_RETURN_FROM_INTERRUPT = 8'hBF;
	localparam logic [3:0]  LO_DECREMENT_BRANCH       = 4'hA;
	localparam logic [3:0]  LO_ABSOLUTE_JUMP_CC       = 4'hD;
	localparam int          FLAGS_BYTE_TOP            = 7;
	localparam logic [11:0] SP_STEP_FLAGS             = 12'h001;
	localparam logic [11:0] SP_STEP_PC                = 12'h002;
	localparam logic [2:0]  NBYTES_RESET              = 3'h1;
	localparam logic [3:0]  NCYCLES_RESET             = 4'h2;

	// ----------------------------------------------------------------
	// Carried types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic c;
		logic z;
		logic s;
		logic v;
		logic d;
		logic h;
	} cod_flags_t;

	typedef struct packed {
		logic [2:0] nbytes;
		logic [3:0] ncycles;
		cod_flags_t aff;
		cod_flags_t undef;
		logic       illegal;
	} cod_info_t;

	typedef struct packed {
		logic [2:0]  bit_idx;
		logic        polarity;
		logic [15:0] direct_address_operand;
		logic [11:0] extended_reg_operand;
		logic [7:0]  immediate_operand;
		logic [7:0]  reg_pair_addr;
		logic [3:0]  work_pair;
		logic [3:0]  work_reg;
		logic [7:0]  rel_disp;
		logic [3:0]  condition_field;
	} cod_opnd_t;

	typedef struct packed {
		logic        valid;
		logic [7:0]  opcode;
		cod_info_t   info;
		cod_opnd_t   opnd;
		logic        pc_load;
		logic [15:0] pc_target;
		logic        wb_en;
		logic [3:0]  wb_reg;
		logic [7:0]  wb_val;
		cod_flags_t  flags;
		logic        ie_set;
		logic [11:0] sp_out;
	} cod_result_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_LOOK,
		ST_OPND,
		ST_EXEC,
		ST_POP_F,
		ST_POP_H,
		ST_POP_L
	} cod_state_t;

endpackage

// file: hw/cod_op_rom.sv
// Opcode table giving length, cycle count and flag behaviour, registered.
`timescale 1ns/1ps
module cod_op_rom (
	input  wire logic              sys_clk,
	input  wire logic              srst,
	input  wire logic [7:0]        opcode,
	output cod_pkg::cod_info_t     info_r
);
	import cod_pkg::*;

	cod_info_t info_nxt;
	logic [3:0] hi;
	logic [3:0] lo;

	// Looks up the byte count, cycle count and flag classes of one opcode.
	always_comb begin
		hi = opcode[7:4];
		lo = opcode[3:0];
		info_nxt = '0;
		info_nxt.nbytes = 3'd2;
		info_nxt.ncycles = 4'd3;
		case (lo)
			4'h0: begin
				info_nxt.ncycles = (hi == 4'h8 || hi == 4'hA) ? 4'd5 : 4'd2;
				if (hi == 4'h0) begin
					info_nxt.nbytes = 3'd1;
					info_nxt.ncycles = 4'd1;
				end
			end
			4'h1: info_nxt.ncycles = (hi == 4'h8 || hi == 4'hA) ? 4'd6 :
				(hi == 4'h0) ? 4'd2 : 4'd3;
			4'h2: info_nxt.ncycles = (hi inside {4'h8, 4'h9, 4'hC, 4'hD}) ? 4'd5 :
				(hi == 4'hE) ? 4'd2 : (hi == 4'hF) ? 4'd6 : 4'd3;
			4'h3: info_nxt.ncycles = (hi inside {4'h8, 4'h9, 4'hC, 4'hD}) ? 4'd9 :
				(hi >= 4'hE) ? 4'd3 : 4'd4;
			4'h4: begin
				info_nxt.nbytes = (hi >= 4'hC && hi != 4'hE) ? 3'd2 : 3'd3;
				info_nxt.ncycles = (hi inside {4'h8, 4'h9, 4'hE}) ? 4'd2 :
					(hi == 4'hD) ? 4'd6 : (hi == 4'hF) ? 4'd8 : 4'd3;
			end
			4'h5: begin
				info_nxt.nbytes = (hi == 4'hC || hi == 4'hD) ? 3'd2 : 3'd3;
				info_nxt.ncycles = (hi inside {4'h8, 4'h9, 4'hE, 4'hF}) ? 4'd3 :
					(hi == 4'hC) ? 4'd9 : (hi == 4'hD) ? 4'd2 : 4'd4;
			end
			4'h6: begin
				info_nxt.nbytes = 3'd3;
				info_nxt.ncycles = (hi == 4'h8 || hi == 4'h9) ? 4'd4 :
					(hi == 4'hE) ? 4'd2 : 4'd3;
				info_nxt.illegal = (hi == 4'hC);
			end
			4'h7: begin
				info_nxt.nbytes = 3'd3;
				info_nxt.ncycles = (hi == 4'h8 || hi == 4'h9) ? 4'd5 :
					(hi == 4'hE) ? 4'd3 : 4'd4;
			end
			4'h8, 4'h9: begin
				info_nxt.nbytes = (hi >= 4'h8 && hi <= 4'hD && hi != 4'hA &&
					hi != 4'hB) ? 3'd3 : 3'd4;
				info_nxt.ncycles = (hi == 4'h8) ? 4'd4 : (hi == 4'hE) ? 4'd2 :
					(hi == 4'hC || hi == 4'hD) ? 4'd2 : 4'd3;
				if (hi == 4'h9)
					info_nxt.ncycles = lo[0] ? 4'd5 : 4'd3;
				info_nxt.illegal = (hi == 4'hF) || (lo[0] && hi >= 4'hC && hi != 4'hE);
			end
			4'hA: info_nxt.ncycles = 4'd3;
			4'hB, 4'hC: info_nxt.ncycles = 4'd2;
			4'hD: begin
				info_nxt.nbytes = 3'd3;
				info_nxt.ncycles = 4'd2;
			end
			default: begin
				info_nxt.nbytes = 3'd1;
				info_nxt.ncycles = (hi == 4'hA) ? 4'd4 : (hi == 4'hB) ? 4'd5 : 4'd2;
				info_nxt.illegal = (lo == 4'hF) && (hi inside {4'h2, 4'h3, 4'h4, 4'hF});
			end
		endcase
		// Marks result-dependent and undefined flags per opcode.
		case (opcode)
			8'h40, 8'h41: begin
				info_nxt.aff = '{c: 1'b1, z: 1'b1, s: 1'b1, default: 1'b0};
				info_nxt.undef = '{v: 1'b1, default: 1'b0};
			end
			8'h30, 8'h31, 8'h80, 8'h81, 8'hA0, 8'hA1:
				info_nxt.aff = '{z: 1'b1, s: 1'b1, v: 1'b1, default: 1'b0};
			8'h20, 8'h21:
				info_nxt.aff = '{z: 1'b1, s: 1'b1, default: 1'b0};
			OPC_RETURN_FROM_INTERRUPT:
				info_nxt.aff = '1;
			default: begin
				if (lo == 4'hE && hi != 4'hF)
					info_nxt.aff = '{z: 1'b1, s: 1'b1, default: 1'b0};
			end
		endcase
	end

	// Registers the table entry.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			info_r <= '{nbytes: NBYTES_RESET, ncycles: NCYCLES_RESET, default: '0};
		end else begin
			info_r <= info_nxt;
		end
	end

endmodule

// file: testbench/cod_decoder_sva.sv
// Concurrent checks of the decoder outputs.
`timescale 1ns/1ps
module cod_decoder_sva
	import cod_pkg::*;
(
	input wire logic                 sys_clk,
	input wire logic                 srst,
	input wire logic                 pm_ready,
	input wire logic                 busy,
	input wire cod_pkg::cod_flags_t  cur_flags,
	input wire logic [7:0]           wreg_val,
	input wire logic [15:0]          pc_seq,
	input wire logic                 stk_req,
	input wire logic [11:0]          stk_addr,
	input wire logic                 stk_ack,
	input wire cod_pkg::cod_result_t result
);
	// Kind of instruction whose result is out.
	logic decrement_branch_nonzero;
	logic jpcc;
	assign decrement_branch_nonzero = result.valid && result.opcode[3:0] == LO_DECREMENT_BRANCH;
	assign jpcc = result.valid && result.opcode[3:0] == LO_ABSOLUTE_JUMP_CC;

	default clocking dc @(posedge sys_clk);
	endclocking
	default disable iff (srst);

	a_valid_pulse: assert property (result.valid |=> !result.valid)
		else $error("valid held");
	a_idle_ready: assert property (!busy |-> pm_ready && !stk_req)
		else $error("idle not ready");
	a_decrement_branch_nonzero_dec: assert property (decrement_branch_nonzero |-> result.wb_en && result.wb_val == $past(wreg_val) - 8'h01)
		else $error("bad decrement");
	a_decrement_branch_nonzero_take: assert property (decrement_branch_nonzero |-> result.pc_load == (result.wb_val != 8'h00))
		else $error("bad branch");
	a_decrement_branch_nonzero_target: assert property (decrement_branch_nonzero && result.pc_load |->
		result.pc_target == $past(pc_seq) + {{8{result.opnd.rel_disp[7]}}, result.opnd.rel_disp})
		else $error("bad displacement");
	a_jump_target: assert property (jpcc && result.pc_load |->
		result.pc_target == result.opnd.direct_address_operand)
		else $error("bad jump target");
	a_jump_fixed: assert property (jpcc && result.opnd.condition_field[2:0] == 3'h0 |->
		result.pc_load == result.opnd.condition_field[3])
		else $error("bad fixed condition");
	a_return_from_interrupt_done: assert property (result.valid && result.opcode == OPC_RETURN_FROM_INTERRUPT |->
		result.ie_set && result.pc_load)
		else $error("bad return");
	a_stack_hold: assert property (stk_req && !stk_ack |=> stk_req && $stable(stk_addr))
		else $error("stack request dropped");
	a_stack_step: assert property (stk_req && stk_ack ##1 stk_req |->
		stk_addr == $past(stk_addr) + 12'h001)
		else $error("bad stack step");
	a_pair_even: assert property (result.valid |->
		result.opnd.reg_pair_addr == {result.opnd.direct_address_operand[15:9], 1'b0} &&
		result.opnd.work_pair == {result.opnd.direct_address_operand[11:9], 1'b0})
		else $error("odd pair");
	a_flags_kept: assert property (result.valid && result.opcode != OPC_RETURN_FROM_INTERRUPT |->
		result.flags == $past(cur_flags))
		else $error("flags changed");
endmodule

bind cod_decoder cod_decoder_sva i_cod_decoder_sva (.sys_clk(sys_clk), .srst(srst),
	.pm_ready(pm_ready), .busy(busy), .cur_flags(cur_flags), .wreg_val(wreg_val),
	.pc_seq(pc_seq), .stk_req(stk_req), .stk_addr(stk_addr), .stk_ack(stk_ack),
	.result(result));

// file: testbench/cod_pm_model.sv
// Program memory and stack memory on the decoder's far side.
`timescale 1ns/1ps
module cod_pm_model (
	input wire logic        sys_clk,
	input wire logic        pm_ready,
	output logic            pm_valid,
	output logic [7:0]      pm_data,
	input wire logic        stk_req,
	input wire logic [11:0] stk_addr,
	output logic            stk_ack,
	output logic [7:0]      stk_data
);
	logic [7:0] prog [0:255];
	logic [7:0] stk [0:4095];
	int         len = 0;
	int         ptr = 0;
	int         lat = 0;
	int         cnt = 0;

	// A byte is taken at the rising edge where both sides agree.
	always @(posedge sys_clk) begin
		if (pm_valid && pm_ready) begin
			ptr <= ptr + 1;
		end
	end

	// Idle data lines show the inverse of their last value.
	initial begin
		pm_valid = 1'b0;
		pm_data = 8'hA5;
		stk_ack = 1'b0;
		stk_data = 8'h5A;
	end
	always @(negedge sys_clk) begin
		pm_valid <= ptr < len;
		pm_data <= (ptr < len) ? prog[ptr] : ~pm_data;
		if (stk_req && cnt >= lat) begin
			stk_ack <= 1'b1;
			stk_data <= stk[stk_addr];
			cnt <= 0;
		end else begin
			stk_ack <= 1'b0;
			stk_data <= ~stk_data;
			cnt <= stk_req ? cnt + 1 : 0;
		end
	end
endmodule

// file: testbench/cod_decoder_tb_top.sv
// Self-checking bench of the operand and branch decoder.
`timescale 1ns/1ps
module cod_decoder_tb_top;
	import cod_pkg::*;
	logic        sys_clk;
	logic        srst;
	logic        pm_valid;
	logic [7:0]  pm_data;
	logic        pm_ready;
	cod_flags_t  cur_flags;
	logic [3:0]  wreg_sel;
	logic [7:0]  wreg_val;
	logic [15:0] pc_seq;
	logic [11:0] sp_in;
	logic        stk_req;
	logic [11:0] stk_addr;
	logic        stk_ack;
	logic [7:0]  stk_data;
	cod_result_t result;
	logic        busy;
	int          fails = 0;
	int          checked = 0;

	// Design and its memory partner.
	cod_decoder i_cod_decoder (.sys_clk(sys_clk), .srst(srst), .pm_valid(pm_valid),
		.pm_data(pm_data), .pm_ready(pm_ready), .cur_flags(cur_flags), .wreg_sel(wreg_sel),
		.wreg_val(wreg_val), .pc_seq(pc_seq), .sp_in(sp_in), .stk_req(stk_req),
		.stk_addr(stk_addr), .stk_ack(stk_ack), .stk_data(stk_data), .result(result),
		.busy(busy));
	cod_pm_model i_cod_pm_model (.sys_clk(sys_clk), .pm_ready(pm_ready), .pm_valid(pm_valid),
		.pm_data(pm_data), .stk_req(stk_req), .stk_addr(stk_addr), .stk_ack(stk_ack),
		.stk_data(stk_data));

	// Clock of 4 ns period.
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic put(input logic [7:0] b);
		i_cod_pm_model.prog[i_cod_pm_model.len] = b;
		i_cod_pm_model.len++;
	endtask

	task automatic drive(input cod_flags_t f, input logic [7:0] w, input logic [15:0] pc,
		input logic [11:0] sp);
		@(negedge sys_clk);
		cur_flags = f;
		wreg_val = w;
		pc_seq = pc;
		sp_in = sp;
	endtask

	// Waits a bounded time for the next result pulse.
	task automatic wait_res;
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (result.valid !== 1'b1 && n < 60);
		cmp("result_valid", 16'h1, 16'(result.valid));
		cmp("busy_done", 16'h0, 16'(busy));
	endtask

	// Jump with only zero set under fixed, zero, signed and carry conditions.
	task automatic s_jump;
		logic [3:0] cc [8] = '{4'h0, 4'h8, 4'h6, 4'hE, 4'h2, 4'hA, 4'h7, 4'hF};
		logic [7:0] take = 8'h96;
		for (int i = 0; i < 8; i++) begin
			drive(6'b010000, 8'h00, 16'h0100, 12'h000);
			put({cc[i], LO_ABSOLUTE_JUMP_CC});
			put(8'h12);
			put(8'h34);
			wait_res();
			cmp("pc_load", 16'(take[i]), 16'(result.pc_load));
			cmp("pc_target", take[i] ? 16'h1234 : 16'h0100, result.pc_target);
			cmp("direct", 16'h1234, result.opnd.direct_address_operand);
			cmp("nbytes", 16'h3, 16'(result.info.nbytes));
		end
	endtask

	// Counted branch falling to zero, then staying nonzero.
	task automatic s_decrement_branch_nonzero;
		for (int i = 0; i < 2; i++) begin
			drive(6'b000000, i ? 8'h05 : 8'h01, 16'h0200, 12'h000);
			put(8'h3A);
			put(8'hFE);
			wait_res();
			cmp("wreg_sel", 16'h3, 16'(wreg_sel));
			cmp("wb_val", i ? 16'h4 : 16'h0, 16'(result.wb_val));
			cmp("pc_load", 16'(i), 16'(result.pc_load));
			cmp("pc_target", i ? 16'h01FE : 16'h0200, result.pc_target);
			cmp("ncycles", 16'h3, 16'(result.info.ncycles));
		end
	endtask

	// Return from interrupt with a prompt and a slow stack.
	task automatic s_return_from_interrupt;
		i_cod_pm_model.stk[12'h0F0] = 8'hA3;
		i_cod_pm_model.stk[12'h0F1] = 8'h12;
		i_cod_pm_model.stk[12'h0F2] = 8'hAB;
		for (int i = 0; i < 2; i++) begin
			i_cod_pm_model.lat = 2 * i;
			drive(6'b000000, 8'h00, 16'h0300, 12'h0F0);
			put(OPC_RETURN_FROM_INTERRUPT);
			wait_res();
			cmp("pc_target", 16'h12AB, result.pc_target);
			cmp("ie_set", 16'h1, 16'(result.ie_set));
			cmp("sp_out", 16'h0F3, 16'(result.sp_out));
			cmp("flags", 16'h28, 16'(result.flags));
			cmp("aff", 16'h3F, 16'(result.info.aff));
			cmp("nbytes", 16'h1, 16'(result.info.nbytes));
		end
	endtask

	// Operand fields of immediate, extended, bit test and pair forms.
	task automatic s_opnd;
		drive(6'b110011, 8'h00, 16'h0400, 12'h000);
		put(8'h3C);
		put(8'hFF);
		wait_res();
		cmp("immediate", 16'hFF, 16'(result.opnd.immediate_operand));
		cmp("flags", 16'h33, 16'(result.flags));
		put(8'h84);
		put(8'hAB);
		put(8'hCD);
		wait_res();
		cmp("extended", 16'hABC, 16'(result.opnd.extended_reg_operand));
		put(8'hE2);
		put(8'hF5);
		wait_res();
		cmp("bit_idx", 16'h7, 16'(result.opnd.bit_idx));
		cmp("polarity", 16'h1, 16'(result.opnd.polarity));
		cmp("work_pair", 16'h4, 16'(result.opnd.work_pair));
		put(8'h86);
		put(8'hFF);
		put(8'h01);
		wait_res();
		cmp("reg_pair", 16'hFE, 16'(result.opnd.reg_pair_addr));
	endtask

	// Reset while an operand is awaited: the decoder drops the opcode and idles.
	task automatic s_reset;
		put(8'h3C);
		repeat (4) @(negedge sys_clk);
		cmp("busy", 16'h1, 16'(busy));
		cmp("pm_ready", 16'h1, 16'(pm_ready));
		srst = 1'b1;
		repeat (2) @(negedge sys_clk);
		srst = 1'b0;
		@(posedge sys_clk);
		#1;
		cmp("busy", 16'h0, 16'(busy));
		cmp("stk_req", 16'h0, 16'(stk_req));
		cmp("pc_target", 16'h0, result.pc_target);
		drive(6'b000001, 8'h00, 16'h0500, 12'h000);
		put(8'h3C);
		put(8'h5A);
		wait_res();
		cmp("immediate", 16'h5A, 16'(result.opnd.immediate_operand));
	endtask

	task automatic end_of_test;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Reset, then the scenarios in turn.
	initial begin
		srst = 1'b1;
		cur_flags = '0;
		wreg_val = 8'h00;
		pc_seq = 16'h0000;
		sp_in = 12'h000;
		repeat (16) @(negedge sys_clk);
		srst = 1'b0;
		s_jump();
		s_decrement_branch_nonzero();
		s_return_from_interrupt();
		s_opnd();
		s_reset();
		end_of_test();
	end

	// Watchdog far above the few hundred nanoseconds the scenarios need.
	initial begin
		#20000;
		fails++;
		end_of_test();
	end
endmodule
